// *** rtcbk_defines.vh ***
/*
 * shared constants of the bcd timekeeper: register addresses, field
 * positions, first-power values, write masks and divider figures.
 * assumes it is included by bare name from the divider and top design files.
 */
`ifndef RTCBK_DEFINES_VH
`define RTCBK_DEFINES_VH

// register addresses
`define RTCBK_ADDR_SEC    6'h00
`define RTCBK_ADDR_MIN    6'h01
`define RTCBK_ADDR_HR     6'h02
`define RTCBK_ADDR_WDAY   6'h03
`define RTCBK_ADDR_DATE   6'h04
`define RTCBK_ADDR_MON    6'h05
`define RTCBK_ADDR_YR     6'h06
`define RTCBK_ADDR_CTRL   6'h07
`define RTCBK_ADDR_RAM0   6'h08
`define RTCBK_ADDR_LAST   6'h3F
`define RTCBK_RAM_WORDS   56

// seven-bit bus address of the device
`define RTCBK_SLAVE_ADDR  7'h68

// field positions
`define RTCBK_HALT_BIT    7
`define RTCBK_MODE12_BIT  6
`define RTCBK_PM_BIT      5
`define RTCBK_OUT_BIT     7
`define RTCBK_SQUARE_WAVE_ENABLE_BIT    4

// first-power values
`define RTCBK_RST_SEC     8'h80
`define RTCBK_RST_MIN     8'h00
`define RTCBK_RST_HR      8'h00
`define RTCBK_RST_WDAY    8'h01
`define RTCBK_RST_DATE    8'h01
`define RTCBK_RST_MON     8'h01
`define RTCBK_RST_YR      8'h00
`define RTCBK_RST_CTRL    8'h03

// bits that exist in each register, all others read zero
`define RTCBK_MASK_MIN    8'h7F
`define RTCBK_MASK_HR     8'h7F
`define RTCBK_MASK_WDAY   8'h07
`define RTCBK_MASK_DATE   8'h3F
`define RTCBK_MASK_MON    8'h1F
`define RTCBK_MASK_CTRL   8'h93

// oscillator divider: 32768 oscillator edges per second
`define RTCBK_DIV_W       15
`define RTCBK_DIV_TOP     15'h7FFF

`endif

// *** rtcbk_sync.v ***
/*
 * two-flop synchroniser for a group of asynchronous pins.
 * assumes each bit is a slow level; reset value set by INIT.
 */
`timescale 1ns/1ns
module rtcbk_sync #(
	parameter       W    = 1,
	parameter [W-1:0] INIT = {W{1'b0}}
) (
	input  wire         sys_clk,
	input  wire         rst_n,
	input  wire         clk_en,
	input  wire [W-1:0] d,
	output reg  [W-1:0] q
);

reg [W-1:0] meta_r;	// first stage, read only by q

// two flops in a row, only the second reads the first
always @(posedge sys_clk or negedge rst_n)
begin
	if (!rst_n)
	begin
		meta_r <= INIT;
		q      <= INIT;
	end
	else if (clk_en)
	begin
		meta_r <= d;
		q      <= meta_r;
	end
end

endmodule // rtcbk_sync

// *** rtcbk_div.v ***
/*
 * sub-second divider chain fed by the synchronised oscillator level.
 * assumes osc_s is already synchronised to sys_clk.
 */
`timescale 1ns/1ns
`include "rtcbk_defines.vh"
module rtcbk_div (
	input  wire                    sys_clk,
	input  wire                    rst_n,
	input  wire                    clk_en,
	input  wire                    osc_s,
	input  wire                    halt,
	input  wire                    clear,
	output reg  [`RTCBK_DIV_W-1:0] cnt_r,
	output reg                     wave32_r,
	output reg                     tick_r
);

reg  osc_d_r;	// previous oscillator level
wire osc_rise;	// one rising oscillator edge while running

assign osc_rise = osc_s & ~osc_d_r & ~halt;

// count oscillator edges; wrap gives the falling edge of the 1 hz wave
always @(posedge sys_clk or negedge rst_n)
begin
	if (!rst_n)
	begin
		osc_d_r  <= 1'b0;
		cnt_r    <= {`RTCBK_DIV_W{1'b0}};
		wave32_r <= 1'b0;
		tick_r   <= 1'b0;
	end
	else if (clk_en)
	begin
		osc_d_r <= osc_s;
		tick_r  <= 1'b0;
		// oscillator wave freezes while halted
		if (!halt)
			wave32_r <= osc_s;
		if (clear)
			cnt_r <= {`RTCBK_DIV_W{1'b0}};
		else if (osc_rise)
		begin
			cnt_r  <= cnt_r + 1'b1;
			tick_r <= (cnt_r == `RTCBK_DIV_TOP);
		end
	end
end

endmodule // rtcbk_div

// *** rtcbk_top.v ***
/*
 * bcd timekeeper: two-wire slave port, clock and calendar counters,
 * user snapshot buffers, control register, general ram and pointer.
 * assumes scl, sda and the 32.768 khz oscillator are asynchronous pins.
 */
`timescale 1ns/1ns
`include "rtcbk_defines.vh"
module rtcbk_top (
	input  wire sys_clk,
	input  wire rst_n,
	input  wire clk_en,
	input  wire scl_pin,
	input  wire sda_pin_in,
	output reg  sda_pin_out_r,
	output reg  sda_pin_oe_n_r,
	input  wire osc_pin,
	output reg  square_wave_pin
);

// bus states
localparam [1:0] ST_IDLE = 2'b00;	// not addressed
localparam [1:0] ST_ADDR = 2'b01;	// taking the address byte
localparam [1:0] ST_WR   = 2'b10;	// master writes to us
localparam [1:0] ST_RD   = 2'b11;	// we send to the master

// synchronised pins and their previous levels
wire [2:0] pins_s;	// {osc, sda, scl} after two flops
wire       scl_s;	// synchronised clock line
wire       sda_s;	// synchronised data line
wire       osc_s;	// synchronised oscillator
reg        scl_d_r;	// scl one cycle back
reg        sda_d_r;	// sda one cycle back

// bus engine state
reg  [1:0] st_r;	// bus state
reg  [3:0] bit_cnt_r;	// bits seen in this byte, 9 = ack clock
reg  [7:0] shift_r;	// incoming byte
reg  [7:0] tx_r;	// outgoing byte, msb next
reg        rw_r;	// direction of this transfer
reg        first_r;	// next written byte is the pointer
reg        drive_r;	// pull sda low

// register file
reg  [5:0] ptr_r;	// register pointer
reg  [7:0] sec_r;	// seconds, bit 7 halts
reg  [7:0] min_r;	// minutes
reg  [7:0] hr_r;	// hours with mode and pm
reg  [7:0] wday_r;	// day of week
reg  [7:0] date_r;	// day of month
reg  [7:0] mon_r;	// month
reg  [7:0] yr_r;	// year
reg  [7:0] ctrl_r;	// output pin control
reg  [7:0] ubuf_r [0:6];	// read snapshot of the time registers
reg  [7:0] ram_r [0:`RTCBK_RAM_WORDS-1];	// general ram
integer    i;	// loop index, unused; the snapshot is loaded without a loop

// divider outputs
wire [`RTCBK_DIV_W-1:0] div_cnt;	// sub-second count
wire       wave32;	// oscillator-rate wave
wire       tick;	// one pulse per second

// bus events
wire scl_rise;	// scl low to high
wire scl_fall;	// scl high to low
wire bus_start;	// start or repeated start
wire bus_stop;	// stop condition
wire wr_evt;	// data or pointer byte acknowledged
wire rd_evt;	// sent byte finished
wire data_wr;	// data byte to store
wire sec_wr;	// seconds being written
wire [5:0] ram_idx;	// ram word for the pointer
reg  [7:0] rd_byte;	// byte the pointer selects
reg  [5:0] ptr_nxt;	// pointer after one step

// next values after one second
reg  [7:0] sec_nxt;
reg  [7:0] min_nxt;
reg  [7:0] hr_nxt;
reg  [7:0] wday_nxt;
reg  [7:0] date_nxt;
reg  [7:0] mon_nxt;
reg  [7:0] yr_nxt;
reg  [8:0] st9;	// scratch {carry, value}
reg        carry;	// ripple into the next field
reg        wave_sel;	// chosen square wave

// one bcd step with wrap from top to bottom, carry on wrap
function [8:0] bcd_step;
	input [7:0] v;
	input [7:0] lo;
	input [7:0] hi;
	begin
		if (v == hi)
			bcd_step = {1'b1, lo};
		else if (v[3:0] == 4'h9)
			bcd_step = {1'b0, v[7:4] + 4'h1, 4'h0};
		else
			bcd_step = {1'b0, v[7:4], v[3:0] + 4'h1};
	end
endfunction

// last date of a month, leap every fourth year
function [7:0] month_end;
	input [7:0] mon;
	input [7:0] yr;
	reg         leap;
	begin
		leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6) :
			(yr[3:0] == 4'h0 || yr[3:0] == 4'h4 ||
			 yr[3:0] == 4'h8);
		case (mon)
			8'h02: month_end = leap ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: month_end = 8'h30;
			default: month_end = 8'h31;
		endcase
	end
endfunction

// pins pass two flops before any logic sees them
rtcbk_sync #(
	.W    (3),
	.INIT (3'b011)
) u_sync (
	.sys_clk (sys_clk),
	.rst_n   (rst_n),
	.clk_en  (clk_en),
	.d       ({osc_pin, sda_pin_in, scl_pin}),
	.q       (pins_s)
);

assign scl_s = pins_s[0];
assign sda_s = pins_s[1];
assign osc_s = pins_s[2];

// divider halts with the halt bit, clears on a seconds write
rtcbk_div u_div (
	.sys_clk  (sys_clk),
	.rst_n    (rst_n),
	.clk_en   (clk_en),
	.osc_s    (osc_s),
	.halt     (sec_r[`RTCBK_HALT_BIT]),
	.clear    (sec_wr),
	.cnt_r    (div_cnt),
	.wave32_r (wave32),
	.tick_r   (tick)
);

// line edges and bus conditions
assign scl_rise  = scl_s & ~scl_d_r;
assign scl_fall  = ~scl_s & scl_d_r;
assign bus_start = scl_s & scl_d_r & sda_d_r & ~sda_s;
assign bus_stop  = scl_s & scl_d_r & ~sda_d_r & sda_s;
assign wr_evt    = scl_fall & (bit_cnt_r == 4'd8) & (st_r == ST_WR);
assign rd_evt    = scl_fall & (bit_cnt_r == 4'd8) & (st_r == ST_RD);
assign data_wr   = wr_evt & ~first_r;
assign sec_wr    = data_wr & (ptr_r == `RTCBK_ADDR_SEC);
assign ram_idx   = ptr_r - `RTCBK_ADDR_RAM0;

// read mux: time from the snapshot, control and ram direct
always @*
begin
	if (ptr_r < `RTCBK_ADDR_CTRL)
		rd_byte = ubuf_r[ptr_r[2:0]];
	else if (ptr_r == `RTCBK_ADDR_CTRL)
		rd_byte = ctrl_r;
	else
		rd_byte = ram_r[ram_idx];
	// pointer wraps past the last ram byte
	if (ptr_r == `RTCBK_ADDR_LAST)
		ptr_nxt = 6'h00;
	else
		ptr_nxt = ptr_r + 6'h01;
end

// bus engine: sample on scl rise, drive on scl fall
always @(posedge sys_clk or negedge rst_n)
begin
	if (!rst_n)
	begin
		scl_d_r   <= 1'b1;
		sda_d_r   <= 1'b1;
		st_r      <= ST_IDLE;
		bit_cnt_r <= 4'd0;
		shift_r   <= 8'h00;
		tx_r      <= 8'h00;
		rw_r      <= 1'b0;
		first_r   <= 1'b0;
		drive_r   <= 1'b0;
	end
	else if (clk_en)
	begin
		scl_d_r <= scl_s;
		sda_d_r <= sda_s;
		if (bus_start)
		begin
			// any start begins a fresh address byte
			st_r      <= ST_ADDR;
			bit_cnt_r <= 4'd0;
			drive_r   <= 1'b0;
		end
		else if (bus_stop)
		begin
			st_r    <= ST_IDLE;
			drive_r <= 1'b0;
		end
		else if (st_r != ST_IDLE && scl_rise)
		begin
			if (bit_cnt_r < 4'd8)
				shift_r <= {shift_r[6:0], sda_s};
			// master not acknowledging ends a read
			if (st_r == ST_RD && bit_cnt_r == 4'd8 && sda_s)
				st_r <= ST_IDLE;
			bit_cnt_r <= bit_cnt_r + 4'd1;
		end
		else if (st_r != ST_IDLE && scl_fall)
		begin
			if (bit_cnt_r == 4'd8)
			begin
				case (st_r)
					ST_ADDR:
					begin
						// only our address is acknowledged
						if (shift_r[7:1] == `RTCBK_SLAVE_ADDR)
						begin
							drive_r <= 1'b1;
							rw_r    <= shift_r[0];
							first_r <= ~shift_r[0];
						end
						else
							st_r <= ST_IDLE;
					end
					ST_WR:
						drive_r <= 1'b1;
					default:
						drive_r <= 1'b0;	// release for master ack
				endcase
			end
			else if (bit_cnt_r == 4'd9)
			begin
				bit_cnt_r <= 4'd0;
				if (st_r == ST_WR && first_r)
					first_r <= 1'b0;
				if (st_r == ST_RD || (st_r == ST_ADDR && rw_r))
				begin
					// load next byte at the held pointer
					st_r    <= ST_RD;
					tx_r    <= {rd_byte[6:0], 1'b0};
					drive_r <= ~rd_byte[7];
				end
				else
				begin
					st_r    <= ST_WR;
					drive_r <= 1'b0;
				end
			end
			else if (st_r == ST_RD)
			begin
				// shift the remaining bits out msb first
				drive_r <= ~tx_r[7];
				tx_r    <= {tx_r[6:0], 1'b0};
			end
		end
	end
end

// pointer: loaded by first byte, stepped after each data byte
always @(posedge sys_clk or negedge rst_n)
begin
	if (!rst_n)
		ptr_r <= 6'h00;
	else if (clk_en)
	begin
		if (wr_evt && first_r)
			ptr_r <= shift_r[5:0];
		else if (data_wr || rd_evt)
			ptr_r <= ptr_nxt;
	end
end

// one-second cascade of all counters
always @*
begin
	sec_nxt  = {1'b0, sec_r[6:0]};
	min_nxt  = min_r;
	hr_nxt   = hr_r;
	wday_nxt = wday_r;
	date_nxt = date_r;
	mon_nxt  = mon_r;
	yr_nxt   = yr_r;
	carry    = 1'b0;
	st9      = bcd_step({1'b0, sec_r[6:0]}, 8'h00, 8'h59);
	sec_nxt  = st9[7:0];
	if (st9[8])
	begin
		st9     = bcd_step(min_r, 8'h00, 8'h59);
		min_nxt = st9[7:0];
		if (st9[8])
		begin
			if (!hr_r[`RTCBK_MODE12_BIT])
			begin
				// 24-hour: bit 5 is the second tens bit
				st9    = bcd_step({2'b00, hr_r[5:0]}, 8'h00, 8'h23);
				hr_nxt = {2'b00, st9[5:0]};
				carry  = st9[8];
			end
			else if (hr_r[4:0] == 5'h11)
			begin
				// 11 to 12 flips am/pm, day ends at pm
				hr_nxt = {2'b01, ~hr_r[`RTCBK_PM_BIT], 5'h12};
				carry  = hr_r[`RTCBK_PM_BIT];
			end
			else if (hr_r[4:0] == 5'h12)
				hr_nxt = {hr_r[7:5], 5'h01};
			else
			begin
				st9    = bcd_step({3'b000, hr_r[4:0]}, 8'h00, 8'h99);
				hr_nxt = {hr_r[7:5], st9[4:0]};
			end
		end
	end
	if (carry)
	begin
		st9      = bcd_step(wday_r, 8'h01, 8'h07);
		wday_nxt = st9[7:0];
		st9      = bcd_step(date_r, 8'h01, month_end(mon_r, yr_r));
		date_nxt = st9[7:0];
		if (st9[8])
		begin
			st9     = bcd_step(mon_r, 8'h01, 8'h12);
			mon_nxt = st9[7:0];
			if (st9[8])
			begin
				st9    = bcd_step(yr_r, 8'h00, 8'h99);
				yr_nxt = st9[7:0];
			end
		end
	end
end

// time registers: tick first, an acknowledged write overrides
always @(posedge sys_clk or negedge rst_n)
begin
	if (!rst_n)
	begin
		sec_r  <= `RTCBK_RST_SEC;
		min_r  <= `RTCBK_RST_MIN;
		hr_r   <= `RTCBK_RST_HR;
		wday_r <= `RTCBK_RST_WDAY;
		date_r <= `RTCBK_RST_DATE;
		mon_r  <= `RTCBK_RST_MON;
		yr_r   <= `RTCBK_RST_YR;
		ctrl_r <= `RTCBK_RST_CTRL;
	end
	else if (clk_en)
	begin
		// tick only arrives while running
		if (tick && !sec_r[`RTCBK_HALT_BIT])
		begin
			sec_r  <= sec_nxt;
			min_r  <= min_nxt;
			hr_r   <= hr_nxt;
			wday_r <= wday_nxt;
			date_r <= date_nxt;
			mon_r  <= mon_nxt;
			yr_r   <= yr_nxt;
		end
		if (data_wr)
		begin
			// stored masked so unused bits read zero
			case (ptr_r)
				`RTCBK_ADDR_SEC:  sec_r  <= shift_r;
				`RTCBK_ADDR_MIN:  min_r  <= shift_r & `RTCBK_MASK_MIN;
				`RTCBK_ADDR_HR:   hr_r   <= shift_r & `RTCBK_MASK_HR;
				`RTCBK_ADDR_WDAY: wday_r <= shift_r & `RTCBK_MASK_WDAY;
				`RTCBK_ADDR_DATE: date_r <= shift_r & `RTCBK_MASK_DATE;
				`RTCBK_ADDR_MON:  mon_r  <= shift_r & `RTCBK_MASK_MON;
				`RTCBK_ADDR_YR:   yr_r   <= shift_r;
				`RTCBK_ADDR_CTRL: ctrl_r <= shift_r & `RTCBK_MASK_CTRL;
				default:          yr_r   <= yr_r;	// ram handled apart
			endcase
		end
	end
end

// snapshot on start, ram writes; ram holds no reset
always @(posedge sys_clk)
begin
	if (clk_en)
	begin
		if (bus_start)
		begin
			ubuf_r[0] <= sec_r;
			ubuf_r[1] <= min_r;
			ubuf_r[2] <= hr_r;
			ubuf_r[3] <= wday_r;
			ubuf_r[4] <= date_r;
			ubuf_r[5] <= mon_r;
			ubuf_r[6] <= yr_r;
		end
		if (data_wr && ptr_r >= `RTCBK_ADDR_RAM0)
			ram_r[ram_idx] <= shift_r;
	end
end

// square wave rate selection
always @*
begin
	case (ctrl_r[1:0])
		2'b00:   wave_sel = div_cnt[14];	// 1 hz
		2'b01:   wave_sel = div_cnt[2];	// 4.096 khz
		2'b10:   wave_sel = div_cnt[1];	// 8.192 khz
		default: wave_sel = wave32;	// 32.768 khz
	endcase
end

// output pins come straight from flops
always @(posedge sys_clk or negedge rst_n)
begin
	if (!rst_n)
	begin
		sda_pin_out_r   <= 1'b0;
		sda_pin_oe_n_r  <= 1'b1;
		square_wave_pin <= 1'b0;
	end
	else if (clk_en)
	begin
		sda_pin_out_r  <= 1'b0;
		sda_pin_oe_n_r <= ~drive_r;
		if (ctrl_r[`RTCBK_SQUARE_WAVE_ENABLE_BIT])
			square_wave_pin <= wave_sel;
		else
			square_wave_pin <= ctrl_r[`RTCBK_OUT_BIT];
	end
end

endmodule // rtcbk_top

// *** rtcbk_i2c_master.sv ***
/*
 * bus master model: start, stop and byte transfers on scl and sda.
 * assumes an open-drain data wire with a pull-up outside this module.
 */
`timescale 1ns/1ns
module rtcbk_i2c_master (
	input  wire sys_clk,  // system clock, paces every bus phase
	input  wire sda_wire, // resolved level of the data wire
	output reg  scl_pin,  // bus clock, high when idle
	output reg  sda_low   // high pulls the data wire low
);
	localparam HALF = 10; // cycles in one bus phase

	// idle bus: clock high, data released
	initial
	begin
		scl_pin = 1'b1;
		sda_low = 1'b0;
	end

	// wait one bus phase
	task wt;
		repeat (HALF) @(posedge sys_clk);
	endtask

	// start or repeated start: data falls while the clock is high
	task start_c;
	begin
		sda_low <= 1'b0;
		wt();
		scl_pin <= 1'b1;
		wt();
		sda_low <= 1'b1;
		wt();
		scl_pin <= 1'b0;
		wt();
	end
	endtask

	// stop: data rises while the clock is high
	task stop_c;
	begin
		sda_low <= 1'b1;
		wt();
		scl_pin <= 1'b1;
		wt();
		sda_low <= 1'b0;
		wt();
	end
	endtask

	// one bit: data set while the clock is low, sampled at end of high
	task bit_c(input logic b, output logic r);
	begin
		sda_low <= ~b;
		wt();
		scl_pin <= 1'b1;
		wt();
		r = sda_wire;
		scl_pin <= 1'b0;
		wt();
	end
	endtask

	// byte msb first, then the ninth bit; a 1 bit releases the wire
	task xfer(input logic [7:0] tx, input logic a9,
		output logic [7:0] rx, output logic r9);
		logic b;
	begin
		for (int i = 7; i >= 0; i--)
		begin
			bit_c(tx[i], b);
			rx[i] = b;
		end
		bit_c(a9, r9);
	end
	endtask
endmodule // rtcbk_i2c_master

// *** rtcbk_assertions.sv ***
/*
 * checker: bus pin timing and output pin relations of the timekeeper.
 * assumes it is bound to rtcbk_top and sees only its ports.
 */
`timescale 1ns/1ns
module rtcbk_checker (
	input wire sys_clk,
	input wire rst_n,
	input wire clk_en,
	input wire scl_pin,
	input wire sda_pin_in,
	input wire sda_pin_out_r,
	input wire sda_pin_oe_n_r,
	input wire osc_pin,
	input wire square_wave_pin
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	reg       scl_q_r;    // last sampled bus clock
	reg       sda_q_r;    // last sampled data wire
	reg       osc_q_r;    // last sampled oscillator
	reg [7:0] fall_age_r; // cycles since the bus clock fell
	reg [7:0] osc_age_r;  // cycles since the oscillator moved
	reg [3:0] rises_r;    // clock rises since start, saturating
	reg       busy_r;     // between start and stop
	wire      start_w = scl_pin & scl_q_r & sda_q_r & ~sda_pin_in;
	wire      stop_w  = scl_pin & scl_q_r & ~sda_q_r & sda_pin_in;

	// pin history used by the bus and pin relations
	always @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			scl_q_r    <= 1'b1;
			sda_q_r    <= 1'b1;
			osc_q_r    <= 1'b0;
			fall_age_r <= 8'hFF;
			osc_age_r  <= 8'hFF;
			rises_r    <= 4'h0;
			busy_r     <= 1'b0;
		end
		else
		begin
			scl_q_r <= scl_pin;
			sda_q_r <= sda_pin_in;
			osc_q_r <= osc_pin;
			if (scl_q_r & ~scl_pin)
				fall_age_r <= 8'h00;
			else if (fall_age_r != 8'hFF)
				fall_age_r <= fall_age_r + 8'h01;
			if (osc_q_r != osc_pin)
				osc_age_r <= 8'h00;
			else if (osc_age_r != 8'hFF)
				osc_age_r <= osc_age_r + 8'h01;
			if (start_w)
				rises_r <= 4'h0;
			else if (~scl_q_r & scl_pin & (rises_r != 4'hF))
				rises_r <= rises_r + 4'h1;
			if (start_w)
				busy_r <= 1'b1;
			else if (stop_w)
				busy_r <= 1'b0;
		end
	end

	a_reset_quiet: assert property (
		$rose(rst_n) |-> sda_pin_oe_n_r && !square_wave_pin)
		else $error("bus or pin active at reset release");
	a_change_after_fall: assert property (
		$changed(sda_pin_oe_n_r) |-> fall_age_r < 8'd8)
		else $error("data drive moved away from a clock fall");
	a_stable_clock_high: assert property (
		$rose(scl_pin) |=> $stable(sda_pin_oe_n_r) [*8])
		else $error("data drive moved while clock high");
	a_drive_after_byte: assert property (
		$fell(sda_pin_oe_n_r) |-> rises_r >= 4'd8)
		else $error("data driven before a whole byte");
	a_drive_stands: assert property (
		$fell(sda_pin_oe_n_r) |=> !sda_pin_oe_n_r [*8])
		else $error("driven bit released too early");
	a_idle_released: assert property (
		!busy_r |-> sda_pin_oe_n_r)
		else $error("data driven on an idle bus");
	a_open_drain: assert property (
		sda_pin_out_r == 1'b0)
		else $error("data drive value not low");
	a_pin_cause: assert property (
		$changed(square_wave_pin) |->
			osc_age_r < 8'd5 || fall_age_r < 8'd8)
		else $error("output pin moved without a cause");
endmodule // rtcbk_checker

bind rtcbk_top rtcbk_checker chk (
	.sys_clk        (sys_clk),
	.rst_n          (rst_n),
	.clk_en         (clk_en),
	.scl_pin        (scl_pin),
	.sda_pin_in     (sda_pin_in),
	.sda_pin_out_r  (sda_pin_out_r),
	.sda_pin_oe_n_r (sda_pin_oe_n_r),
	.osc_pin        (osc_pin),
	.square_wave_pin(square_wave_pin)
);

// *** testbench.sv ***
/*
 * testbench: drives the timekeeper through the master model and
 * checks registers, masking, pointer wrap and the output pin.
 * assumes the master model and the checker are compiled first.
 */
`timescale 1ns/1ns
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
	num_errors++; $display("BAD %s exp %h got %h", n, e, g); end end
module testbench;
	logic       sys_clk = 1'b0; // 100 mhz clock
	logic       rst_n   = 1'b0; // active low reset
	logic       osc_pin = 1'b0; // oscillator stand-in, 125 ns
	wire        scl_pin;        // bus clock from the master
	wire        sda_low;        // master pulls data low
	wire        sda_oe_n;       // device pulls data low when 0
	wire        sq_pin;         // square wave output
	wire        sda_wire = sda_oe_n & ~sda_low; // pulled-up wire
	int         num_errors  = 0;
	int         comparisons = 0;
	int         n;              // pin transitions seen
	logic       prev;           // last pin level
	logic       ack;            // ninth bit seen by the master
	logic [7:0] rx;             // spare received byte
	logic [7:0] wq[$];          // bytes to write
	logic [7:0] rq[$];          // bytes read back
	// rows: seconds, control, expected transitions in 400 cycles
	logic [23:0] rows[7] = '{24'h00_80_00, 24'h00_00_00, 24'h00_11_08,
		24'h00_12_10, 24'h00_13_40, 24'h80_13_00, 24'h80_10_00};
	logic [7:0] rst_v[8] = '{8'h80, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01,
		8'h00, 8'h03};
	logic [7:0] msk_v[7] = '{8'h59, 8'h72, 8'h01, 8'h01, 8'h01, 8'h00,
		8'h93};
	logic [7:0] wrp_v[3] = '{8'hA5, 8'h5A, 8'h80};

	// clocks: system and free-running oscillator
	always #5 sys_clk = ~sys_clk;
	always
	begin
		// edges kept off the sampling edge of sys_clk, period 125 ns
		#62 osc_pin = 1'b1;
		#61 osc_pin = 1'b0;
		#2;
	end

	rtcbk_top dut (
		.sys_clk        (sys_clk),
		.rst_n          (rst_n),
		.clk_en         (1'b1),
		.scl_pin        (scl_pin),
		.sda_pin_in     (sda_wire),
		.sda_pin_out_r  (),
		.sda_pin_oe_n_r (sda_oe_n),
		.osc_pin        (osc_pin),
		.square_wave_pin(sq_pin)
	);
	rtcbk_i2c_master m (
		.sys_clk (sys_clk),
		.sda_wire(sda_wire),
		.scl_pin (scl_pin),
		.sda_low (sda_low)
	);

	// write: address, pointer byte, then the queued bytes
	task wr(input logic [7:0] p, input logic stp);
	begin
		m.start_c();
		m.xfer(8'hD0, 1'b1, rx, ack);
		`CHK("addr ack", 1'b0, ack)
		m.xfer(p, 1'b1, rx, ack);
		`CHK("ptr ack", 1'b0, ack)
		foreach (wq[i])
		begin
			m.xfer(wq[i], 1'b1, rx, ack);
			`CHK("data ack", 1'b0, ack)
		end
		if (stp)
			m.stop_c();
	end
	endtask

	// read n bytes from the held pointer, last one not acknowledged
	task rd(input int cnt);
	begin
		rq = {};
		m.start_c();
		m.xfer(8'hD1, 1'b1, rx, ack);
		`CHK("read ack", 1'b0, ack)
		for (int i = 0; i < cnt; i++)
		begin
			m.xfer(8'hFF, i == cnt - 1, rx, ack);
			rq.push_back(rx);
		end
		m.stop_c();
	end
	endtask

	// reset pulse of 16 cycles, then room for the synchronisers
	task do_reset;
	begin
		@(posedge sys_clk);
		rst_n <= 1'b0;
		repeat (16) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (8) @(posedge sys_clk);
	end
	endtask

	// counts, verdict and end of run
	task final_report;
	begin
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	end
	endtask

	// watchdog against a hung bus
	initial
	begin
		#900000;
		num_errors++;
		final_report();
	end

	// main sequence
	initial
	begin
		do_reset();
		// output pin rows: halt bit, then control, then watch the pin
		foreach (rows[r])
		begin
			wq = {rows[r][23:16]};
			wr(8'h00, 1'b1);
			wq = {rows[r][15:8]};
			wr(8'h07, 1'b1);
			n = 0;
			prev = sq_pin;
			repeat (400)
			begin
				@(posedge sys_clk);
				#1;
				n += (sq_pin !== prev);
				prev = sq_pin;
			end
			`CHK("toggles", 1'b1, n + 1 >= rows[r][7:0] && n <= rows[r][7:0] + 1)
			if (!rows[r][12])
				`CHK("pin level", rows[r][15], sq_pin)
		end
		// second reset in mid-run, read all registers from pointer 00
		do_reset();
		`CHK("pin after reset", 1'b0, sq_pin)
		rd(8);
		foreach (rst_v[i])
			`CHK("reset reg", rst_v[i], rq[i])
		// constant-zero bits, 12-hour pm, control unused bits
		wq = {8'hD9, 8'h72, 8'h01, 8'h01, 8'h01, 8'h00, 8'hFF};
		wr(8'h01, 1'b1);
		wq = {};
		wr(8'h01, 1'b0);
		rd(7);
		foreach (msk_v[i])
			`CHK("masked reg", msk_v[i], rq[i])
		// hours rewritten together with the format change
		wq = {8'h23};
		wr(8'h02, 1'b1);
		// ram end then wrap onto seconds, read back by repeated start
		wq = {8'hA5, 8'h5A, 8'h80};
		wr(8'h3E, 1'b1);
		wq = {};
		wr(8'h3E, 1'b0);
		rd(3);
		foreach (wrp_v[i])
			`CHK("wrap byte", wrp_v[i], rq[i])
		rd(2);
		`CHK("held ptr", 8'h59, rq[0])
		`CHK("hours 24h", 8'h23, rq[1])
		// foreign address: no acknowledge
		m.start_c();
		m.xfer(8'hD2, 1'b1, rx, ack);
		m.stop_c();
		`CHK("foreign ack", 1'b1, ack)
		final_report();
	end
endmodule // testbench
